// File: rtl/cfg_register_bank.sv
// configuration register bank behind a two-wire serial control port
// What this block does
// - writing one to bit 5 of address 000 restores register defaults
// - that soft reset bit clears itself one serial clock after the write
// - address 002 reads silicon revision, writes ignored
// - address 003 reads fixed variant identification code
// - bit 0 of address 004 picks buffer or active bank for reads
// - addresses 005 and 006 hold sixteen-bit user label, reset zero
// - the user label changes no behaviour of the device
// - bit 7 of address 010 picks detector polarity, zero positive
module cfg_register_bank #(
   parameter logic [6:0] DEV_ADDR = 7'h5C,
   // arbitrary neutral values
   parameter logic [7:0] REVISION = 8'h01,
   parameter logic [7:0] VARIANT_ID = 8'h5A
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // serial control port
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // buffer to active transfer
   input wire logic transfer_i,
   // to the loop and the rest of the chip
   output logic detector_polarity_select_o,
   output logic soft_reset_o
);
   // ==========================================================
   // line events and read mux
   cfg_bank_pkg::line_ev_t ev;
   cfg_bank_pkg::bank_state_t q, d;
   logic wr_fire;
   logic [7:0] wr_byte;

   // refuse a bus address that the serial protocol reserves
   localparam logic [6:0] DEV_ADDR_MIN = 7'h08;
   localparam logic [6:0] DEV_ADDR_MAX = 7'h77;
   if (DEV_ADDR < DEV_ADDR_MIN || DEV_ADDR > DEV_ADDR_MAX) begin : g_reserved_addr
      $error("bus address lies in a reserved range");
   end

   line_sense u_line_sense (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .ev_o(ev)
   );

   function automatic logic [7:0] read_data(input cfg_bank_pkg::bank_state_t s);
      logic [7:0] r;
      r = cfg_bank_pkg::ZERO_BYTE;
      unique case (s.addr)
         cfg_bank_pkg::ADDR_PORT_CFG: begin
            r[cfg_bank_pkg::BIT_SOFT_RESET] = s.sreset;
            r[cfg_bank_pkg::BIT_SOFT_MIRROR] = s.mirror;
         end
         cfg_bank_pkg::ADDR_REVISION: r = REVISION;
         cfg_bank_pkg::ADDR_VARIANT: r = VARIANT_ID;
         cfg_bank_pkg::ADDR_BANK_SEL: r[cfg_bank_pkg::BIT_BANK_ACTIVE] = s.rb_active;
         cfg_bank_pkg::ADDR_UID_LOW: r = s.uid_lo;
         cfg_bank_pkg::ADDR_UID_HIGH: r = s.uid_hi;
         cfg_bank_pkg::ADDR_LOOP_CTRL: begin
            r[cfg_bank_pkg::BIT_POLARITY] = s.rb_active ? s.pol_act : s.pol_buf;
         end
         default: r = cfg_bank_pkg::ZERO_BYTE;
      endcase
      return r;
   endfunction

   assign wr_fire = ev.scl_rise && (q.st == cfg_bank_pkg::S_WR) && (q.bitcnt == cfg_bank_pkg::LAST_BIT);
   assign wr_byte = {q.shreg[6:0], ev.sda};

   // ==========================================================
   // port sequencer and registers
   always_comb begin
      logic [7:0] rd;
      rd = read_data(q);
      d = q;
      d.soft_pulse = 1'b0;
      if (transfer_i) begin
         d.pol_act = q.pol_buf;
      end
      if (q.pend && ev.scl_rise) begin
         d.pend = 1'b0;
         d.sreset = 1'b0;
         d.mirror = 1'b0;
         d.rb_active = 1'b0;
         d.uid_lo = cfg_bank_pkg::UID_RESET;
         d.uid_hi = cfg_bank_pkg::UID_RESET;
         d.pol_buf = 1'b0;
         d.pol_act = 1'b0;
         d.soft_pulse = 1'b1;
      end
      if (ev.start) begin
         d.st = cfg_bank_pkg::S_DEV;
         d.bitcnt = '0;
         d.sda_oe = 1'b0;
      end else if (ev.stop) begin
         d.st = cfg_bank_pkg::S_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            cfg_bank_pkg::S_IDLE: d.sda_oe = 1'b0;
            cfg_bank_pkg::S_DEV, cfg_bank_pkg::S_ADDR_HI, cfg_bank_pkg::S_ADDR_LO,
            cfg_bank_pkg::S_WR: begin
               if (ev.scl_rise) begin
                  d.shreg = wr_byte;
                  d.bitcnt = q.bitcnt + 4'h1;
                  if (q.bitcnt == cfg_bank_pkg::LAST_BIT) begin
                     d.st = cfg_bank_pkg::S_ACK;
                     unique case (q.st)
                        cfg_bank_pkg::S_DEV: begin
                           if (wr_byte[7:1] != DEV_ADDR) begin
                              d.st = cfg_bank_pkg::S_IDLE;
                           end
                           d.after_ack = wr_byte[cfg_bank_pkg::BIT_RW] ?
                              cfg_bank_pkg::S_RD : cfg_bank_pkg::S_ADDR_HI;
                        end
                        cfg_bank_pkg::S_ADDR_HI: begin
                           d.addr = {wr_byte, q.addr[7:0]};
                           d.after_ack = cfg_bank_pkg::S_ADDR_LO;
                        end
                        cfg_bank_pkg::S_ADDR_LO: begin
                           d.addr = {q.addr[15:8], wr_byte};
                           d.after_ack = cfg_bank_pkg::S_WR;
                        end
                        default: begin
                           d.after_ack = cfg_bank_pkg::S_WR;
                           d.addr = q.addr + 16'h0001;
                           unique case (q.addr)
                              cfg_bank_pkg::ADDR_PORT_CFG: begin
                                 d.sreset = wr_byte[cfg_bank_pkg::BIT_SOFT_RESET];
                                 d.mirror = wr_byte[cfg_bank_pkg::BIT_SOFT_MIRROR];
                                 d.pend = wr_byte[cfg_bank_pkg::BIT_SOFT_RESET];
                              end
                              cfg_bank_pkg::ADDR_BANK_SEL:
                                 d.rb_active = wr_byte[cfg_bank_pkg::BIT_BANK_ACTIVE];
                              cfg_bank_pkg::ADDR_UID_LOW: d.uid_lo = wr_byte;
                              cfg_bank_pkg::ADDR_UID_HIGH: d.uid_hi = wr_byte;
                              cfg_bank_pkg::ADDR_LOOP_CTRL:
                                 d.pol_buf = wr_byte[cfg_bank_pkg::BIT_POLARITY];
                              default: d.pend = q.pend;
                           endcase
                        end
                     endcase
                  end
               end
            end
            cfg_bank_pkg::S_ACK: begin
               if (ev.scl_fall && !q.sda_oe) begin
                  d.sda_oe = 1'b1;
               end else if (ev.scl_fall) begin
                  d.bitcnt = '0;
                  d.st = q.after_ack;
                  d.sda_oe = 1'b0;
                  if (q.after_ack == cfg_bank_pkg::S_RD) begin
                     d.sda_oe = ~rd[7];
                     d.shreg = {rd[6:0], 1'b0};
                  end
               end
            end
            cfg_bank_pkg::S_RD: begin
               if (ev.scl_rise) begin
                  d.bitcnt = q.bitcnt + 4'h1;
                  if (q.bitcnt == cfg_bank_pkg::LAST_BIT) begin
                     d.st = cfg_bank_pkg::S_RACK;
                  end
               end else if (ev.scl_fall) begin
                  d.sda_oe = ~q.shreg[7];
                  d.shreg = {q.shreg[6:0], 1'b0};
               end
            end
            cfg_bank_pkg::S_RACK: begin
               if (ev.scl_fall) begin
                  d.sda_oe = 1'b0;
               end else if (ev.scl_rise) begin
                  d.st = ev.sda ? cfg_bank_pkg::S_IDLE : cfg_bank_pkg::S_RD_LOAD;
                  d.addr = ev.sda ? q.addr : q.addr + 16'h0001;
               end
            end
            cfg_bank_pkg::S_RD_LOAD: begin
               if (ev.scl_fall) begin
                  d.st = cfg_bank_pkg::S_RD;
                  d.bitcnt = '0;
                  d.sda_oe = ~rd[7];
                  d.shreg = {rd[6:0], 1'b0};
               end
            end
            default: d.st = cfg_bank_pkg::S_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '{st: cfg_bank_pkg::S_IDLE, after_ack: cfg_bank_pkg::S_IDLE, bitcnt: 4'h0,
                shreg: 8'h00, addr: 16'h0000, uid_lo: cfg_bank_pkg::UID_RESET,
                uid_hi: cfg_bank_pkg::UID_RESET, default: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = q.sda_oe;
   assign detector_polarity_select_o = q.pol_act;
   assign soft_reset_o = q.soft_pulse;

   // ==========================================================
   // assertions
   logic load_now;
   // a read byte is loaded after the address acknowledge or after a host acknowledge
   assign load_now = ev.scl_fall && !ev.start && !ev.stop &&
      ((q.st == cfg_bank_pkg::S_RD_LOAD) ||
       (q.st == cfg_bank_pkg::S_ACK && q.sda_oe && q.after_ack == cfg_bank_pkg::S_RD));

   soft_defaults_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      soft_reset_o |-> (q.uid_lo == 8'h00 && q.uid_hi == 8'h00 && !q.rb_active && !q.pol_buf))
      else $error("soft reset left a register off default");
   soft_cause_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      soft_reset_o |-> $past(q.pend) && $past(ev.scl_rise))
      else $error("soft reset without a pending request");
   self_clear_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (q.pend && ev.scl_rise) |=> (!q.sreset && !q.pend && soft_reset_o))
      else $error("soft reset bit did not clear on next serial clock");
   revision_read_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (load_now && q.addr == cfg_bank_pkg::ADDR_REVISION) |=> (sda_oe_o == ~REVISION[7]))
      else $error("revision readback wrong");
   variant_read_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (load_now && q.addr == cfg_bank_pkg::ADDR_VARIANT) |=> (sda_oe_o == ~VARIANT_ID[7]))
      else $error("variant readback wrong");
   bank_read_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (load_now && q.addr == cfg_bank_pkg::ADDR_LOOP_CTRL) |=>
      (sda_oe_o == ~($past(q.rb_active) ? $past(q.pol_act) : $past(q.pol_buf))))
      else $error("bank select readback wrong");
   label_write_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (wr_fire && q.addr == cfg_bank_pkg::ADDR_UID_HIGH && !(q.pend && ev.scl_rise))
      |=> (q.uid_hi == $past(wr_byte)))
      else $error("user label high byte not stored");
   label_inert_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      ($changed(q.uid_lo) || $changed(q.uid_hi)) && !soft_reset_o && !$past(transfer_i)
      |-> $stable(detector_polarity_select_o))
      else $error("user label changed behaviour");
   polarity_move_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      $changed(detector_polarity_select_o) |-> ($past(transfer_i) || soft_reset_o))
      else $error("polarity changed without transfer");
   unused_zero_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      (load_now && q.addr == cfg_bank_pkg::ADDR_PORT_CFG) |=> sda_oe_o)
      else $error("unused top bit of port config read nonzero");

   soft_reset_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) soft_reset_o);
   read_burst_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q.st == cfg_bank_pkg::S_RACK ##1 q.st == cfg_bank_pkg::S_RD_LOAD);
   polarity_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(detector_polarity_select_o));
endmodule

// File: rtl/cfg_bank_pkg.sv
// shared constants and types for the serial configuration register bank
package cfg_bank_pkg;
   // ==========================================================
   // register addresses
   localparam logic [15:0] ADDR_PORT_CFG = 16'h0000;
   localparam logic [15:0] ADDR_REVISION = 16'h0002;
   localparam logic [15:0] ADDR_VARIANT = 16'h0003;
   localparam logic [15:0] ADDR_BANK_SEL = 16'h0004;
   localparam logic [15:0] ADDR_UID_LOW = 16'h0005;
   localparam logic [15:0] ADDR_UID_HIGH = 16'h0006;
   localparam logic [15:0] ADDR_LOOP_CTRL = 16'h0010;

   // ==========================================================
   // field positions
   localparam int BIT_SOFT_RESET = 5;
   localparam int BIT_SOFT_MIRROR = 2;
   localparam int BIT_BANK_ACTIVE = 0;
   localparam int BIT_POLARITY = 7;
   localparam int BIT_RW = 0;
   localparam logic [3:0] LAST_BIT = 4'h7;

   // ==========================================================
   // reset values
   localparam logic [7:0] UID_RESET = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ==========================================================
   // types
   typedef enum logic [3:0] {
      S_IDLE, S_DEV, S_ADDR_HI, S_ADDR_LO, S_WR, S_ACK, S_RD, S_RACK, S_RD_LOAD
   } port_state_t;

   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic sda;
   } line_ev_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } line_state_t;

   typedef struct packed {
      port_state_t st;
      port_state_t after_ack;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [15:0] addr;
      logic sreset;
      logic mirror;
      logic pend;
      logic rb_active;
      logic [7:0] uid_lo;
      logic [7:0] uid_hi;
      logic pol_buf;
      logic pol_act;
      logic sda_oe;
      logic soft_pulse;
   } bank_state_t;
endpackage

// File: rtl/line_sense.sv
// samples the serial clock and data lines and reports edges, start and stop
module line_sense (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // serial lines
   input wire logic scl_i,
   input wire logic sda_i,
   // events
   output cfg_bank_pkg::line_ev_t ev_o
);
   cfg_bank_pkg::line_state_t q, d;

   always_comb begin
      d.scl = scl_i;
      d.sda = sda_i;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         q <= '{scl: 1'b1, sda: 1'b1};
      end else begin
         q <= d;
      end
   end

   assign ev_o = '{
      scl_rise: scl_i & ~q.scl,
      scl_fall: ~scl_i & q.scl,
      start: scl_i & q.scl & q.sda & ~sda_i,
      stop: scl_i & q.scl & ~q.sda & sda_i,
      sda: sda_i
   };
endmodule

// File: dv/i2c_host_model.sv
// two-wire host model that drives clock and data toward the register bank
module i2c_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h5C
) (
   // clock
   input wire logic sys_clk_i,
   // serial lines
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int half = 6;
   int nacks = 0;
   logic ext_osc = 1'b1;
   logic [6:0] dev_addr = DEV_ADDR;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask
   // data moves only while the clock is low, sampled late in the high phase
   task automatic clock_bit(input logic b, output logic s);
      wait_clk(2);
      sda_o = b;
      wait_clk(half);
      scl_o = 1'b1;
      wait_clk(half);
      s = sda_i;
      scl_o = 1'b0;
   endtask
   task automatic start_cond;
      wait_clk(2);
      sda_o = 1'b1;
      wait_clk(half);
      scl_o = 1'b1;
      wait_clk(half);
      sda_o = 1'b0;
      wait_clk(half);
      scl_o = 1'b0;
   endtask
   task automatic stop_cond;
      wait_clk(2);
      sda_o = 1'b0;
      wait_clk(half);
      scl_o = 1'b1;
      wait_clk(half);
      sda_o = 1'b1;
      wait_clk(half);
   endtask
   // eight bits then the acknowledge bit, low acknowledge means accepted
   task automatic xfer_byte(input logic [7:0] d, input logic hack, output logic [7:0] q,
                            output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(d[i], b);
         q[i] = b;
      end
      clock_bit(hack, ack);
   endtask
   task automatic send(input logic [7:0] d);
      logic [7:0] q;
      logic a;
      xfer_byte(d, 1'b1, q, a);
      if (a !== 1'b0) nacks++;
   endtask
   task automatic write_reg(input logic [15:0] a, input logic [7:0] d);
      if (a == 16'h0000) d[3:0] = {d[4], d[5], d[6], d[7]};
      if (a == 16'h0010 && !ext_osc) d[7] = 1'b0;
      start_cond;
      send({dev_addr, 1'b0});
      send(a[15:8]);
      send(a[7:0]);
      send(d);
      stop_cond;
   endtask
   task automatic read_regs(input logic [15:0] a, input int n, output logic [15:0] q);
      logic [7:0] b;
      logic k;
      start_cond;
      send({dev_addr, 1'b0});
      send(a[15:8]);
      send(a[7:0]);
      start_cond;
      send({dev_addr, 1'b1});
      q = 16'h0000;
      for (int i = 0; i < n; i++) begin
         xfer_byte(8'hFF, (i == n - 1), b, k);
         q = {q[7:0], b};
      end
      stop_cond;
   endtask
endmodule

// File: dv/tb.sv
// self-checking bench for the configuration register bank
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // signals and instances
   localparam logic [6:0] DEV = 7'h5C;
   localparam logic [7:0] REV = 8'h01;
   localparam logic [7:0] VARIANT = 8'h5A;
   typedef struct {logic [15:0] addr; logic [7:0] wdata; logic [7:0] rdata;} row_t;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic transfer = 1'b0;
   logic scl, host_sda, sda_out, sda_oe, polarity, soft_reset;
   logic [15:0] q;
   wire logic sda_line;
   int n_errors = 0;
   int checks = 0;
   int pulses = 0;
   row_t rows [8] = '{
      '{16'h0005, 8'hAB, 8'hAB}, '{16'h0006, 8'hCD, 8'hCD},
      '{16'h0002, 8'hFF, REV}, '{16'h0003, 8'hFF, VARIANT},
      '{16'h0004, 8'h01, 8'h01}, '{16'h0004, 8'h00, 8'h00},
      '{16'h0010, 8'h80, 8'h80}, '{16'h0000, 8'hDB, 8'h00}
   };
   assign sda_line = host_sda & ~(sda_oe & ~sda_out);
   always #2.5 sys_clk = ~sys_clk;
   always @(negedge sys_clk) if (soft_reset === 1'b1) pulses++;
   cfg_register_bank #(.DEV_ADDR(DEV), .REVISION(REV), .VARIANT_ID(VARIANT)) cfg_register_bank_i (
      .sys_clk_i(sys_clk), .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_out), .sda_oe_o(sda_oe), .transfer_i(transfer),
      .detector_polarity_select_o(polarity), .soft_reset_o(soft_reset));
   i2c_host_model #(.DEV_ADDR(DEV)) i2c_host_model_i (
      .sys_clk_i(sys_clk), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));
   // ==========================================================
   // compare and helper tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      i2c_host_model_i.read_regs(a, 1, q);
      chk8(q[7:0], exp);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      i2c_host_model_i.write_reg(a, d);
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (2) @(negedge sys_clk);
      chk1(sda_oe | soft_reset | sda_out, 1'b0);
      chk1(polarity, 1'b0);
      reset_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk1(sda_oe | soft_reset | sda_out, 1'b0);
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].rdata);
      end
      @(negedge sys_clk);
      reset_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk1(sda_oe | soft_reset, 1'b0);
      reset_n = 1'b1;
      repeat (2) @(negedge sys_clk);
      chk1(polarity, 1'b0);
      rd(16'h0005, 8'h00);
      rd(16'h0006, 8'h00);
      rd(16'h0004, 8'h00);
      rd(16'h0010, 8'h00);
      // slow host, one frame reading two bytes with auto-increment
      i2c_host_model_i.half = 12;
      wr(16'h0005, 8'h34);
      wr(16'h0006, 8'h12);
      i2c_host_model_i.read_regs(16'h0005, 2, q);
      chk8(q[15:8], 8'h34);
      chk8(q[7:0], 8'h12);
      i2c_host_model_i.half = 6;
      // polarity reaches the output only after the transfer strobe
      wr(16'h0010, 8'h80);
      chk1(polarity, 1'b0);
      transfer = 1'b1;
      @(negedge sys_clk);
      transfer = 1'b0;
      @(negedge sys_clk);
      chk1(polarity, 1'b1);
      wr(16'h0004, 8'h01);
      rd(16'h0010, 8'h80);
      wr(16'h0005, 8'hFF);
      wr(16'h0006, 8'hFF);
      chk1(polarity, 1'b1);
      chk1(pulses == 0, 1'b1);
      // soft reset, low nibble mirrored by the host
      wr(16'h0000, 8'h20);
      repeat (4) @(negedge sys_clk);
      chk1(pulses == 1, 1'b1);
      chk1(polarity, 1'b0);
      rd(16'h0000, 8'h00);
      rd(16'h0004, 8'h00);
      rd(16'h0005, 8'h00);
      rd(16'h0010, 8'h00);
      chk1(i2c_host_model_i.nacks == 0, 1'b1);
      // a frame for another bus address is never acknowledged and stores nothing
      i2c_host_model_i.dev_addr = ~DEV;
      wr(16'h0005, 8'h77);
      chk1(i2c_host_model_i.nacks == 4, 1'b1);
      i2c_host_model_i.dev_addr = DEV;
      rd(16'h0005, 8'h00);
      stop_test;
   end
   initial begin
      repeat (80000) @(posedge sys_clk);
      n_errors++;
      $display("mismatch at %0t: watchdog expired", $time);
      stop_test;
   end
endmodule
